// [i2chm_pkg.sv]
`default_nettype none
package i2chm_pkg;

  // clock and bus rate
  localparam int CLK_HZ     = 125_000_000;
  localparam int SCL_HZ     = 400_000;
  // quarter bit period, rounded up so the bus never runs fast
  localparam int QTR_CYCLES = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int QTR_W      = 16;

  // frame layout
  localparam int          ADDR_W   = 7;
  localparam int          DATA_W   = 8;
  localparam logic [3:0]  BIT_ACK  = 4'h8;
  localparam logic        RW_WRITE = 1'b0;
  localparam logic        RW_READ  = 1'b1;

  // quarter phases of a bit
  localparam logic [1:0]  PH_0 = 2'h0;
  localparam logic [1:0]  PH_1 = 2'h1;
  localparam logic [1:0]  PH_2 = 2'h2;
  localparam logic [1:0]  PH_3 = 2'h3;

  localparam logic [7:0]  LEN_ONE  = 8'h01;
  localparam logic [7:0]  LEN_ZERO = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_START = 6'b000010,
    ST_BITS  = 6'b000100,
    ST_WAITD = 6'b001000,
    ST_STOP  = 6'b010000,
    ST_SPARE = 6'b100000
  } i2chm_state_type;

  typedef enum logic [2:0] {
    STG_ADDR_W = 3'h0,
    STG_PTR    = 3'h1,
    STG_WDATA  = 3'h2,
    STG_ADDR_R = 3'h3,
    STG_RDATA  = 3'h4
  } i2chm_stage_type;

endpackage : i2chm_pkg
`default_nettype wire

// [i2chm_link_if.sv]
`default_nettype none
interface i2chm_link_if;
  logic sda_s;
  logic scl_s;
  logic tick;
  logic hold;
  modport gen  (output sda_s, output scl_s, output tick, input hold);
  modport core (input sda_s, input scl_s, input tick, output hold);
endinterface : i2chm_link_if
`default_nettype wire

// [i2chm_pin_sync.sv]
`default_nettype none
module i2chm_pin_sync
  import i2chm_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   sda_in,
  input  wire logic   scl_in,
  i2chm_link_if.gen   lnk
);

  logic [1:0]       sda_ff;
  logic [1:0]       scl_ff;
  logic [QTR_W-1:0] qcnt;
  logic             qend;

  // two-flop synchronisers on the pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_ff <= 2'h3;
      scl_ff <= 2'h3;
    end else begin
      sda_ff <= {sda_ff[0], sda_in};
      scl_ff <= {scl_ff[0], scl_in};
    end
  end

  assign lnk.sda_s = sda_ff[1];
  assign lnk.scl_s = scl_ff[1];

  // quarter-period tick, frozen while scl is seen low after release
  assign qend = (qcnt == QTR_W'(QTR - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qcnt <= '0;
    end else if (lnk.hold) begin
      qcnt <= qcnt;
    end else if (qend) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + QTR_W'(1);
    end
  end

  assign lnk.tick = qend & ~lnk.hold;

endmodule : i2chm_pin_sync
`default_nettype wire

// [i2chm_master.sv]
`default_nettype none
module i2chm_master
  import i2chm_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              cmd_valid,
  output var  logic              cmd_ready,
  input  wire logic              cmd_read,
  input  wire logic              cmd_use_ptr,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_ptr,
  input  wire logic [7:0]        cmd_len,
  input  wire logic              wr_valid,
  input  wire logic [DATA_W-1:0] wr_data,
  output var  logic              wr_ready,
  output var  logic              rd_valid,
  output var  logic [DATA_W-1:0] rd_data,
  output var  logic              done,
  output var  logic              nack,
  input  wire logic              sda_in,
  input  wire logic              scl_in,
  output var  logic              sda_out,
  output var  logic              sda_oe,
  output var  logic              scl_out,
  output var  logic              scl_oe
);

  i2chm_link_if lnk ();

  i2chm_pin_sync #(
    .QTR (QTR)
  ) u_sync (
    .clk    (clk),
    .rstn   (rstn),
    .sda_in (sda_in),
    .scl_in (scl_in),
    .lnk    (lnk.gen)
  );

  i2chm_state_type   state;
  i2chm_stage_type   stage;
  logic [1:0]        phase;
  logic [3:0]        bitn;
  logic [DATA_W-1:0] shift;
  logic [7:0]        len;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] ptr;
  logic              rd_cmd;
  logic              sample;
  logic              active;

  // open-drain lines only ever pull low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;

  // wait for a released scl to rise before time runs on
  assign lnk.hold = ~scl_oe & ~lnk.scl_s;

  wire tick      = lnk.tick;
  wire last_ph   = (phase == PH_3);
  wire ack_bit   = (bitn == BIT_ACK);
  wire rx_byte   = (stage == STG_RDATA);
  wire got_ack   = ~sample;
  wire last_rd   = (len == LEN_ONE);
  wire take_cmd  = cmd_valid & cmd_ready;
  wire take_wr   = wr_valid & wr_ready;

  // address byte with direction in bit 0
  wire [DATA_W-1:0] addr_wr = {addr, RW_WRITE};
  wire [DATA_W-1:0] addr_rd = {addr, RW_READ};
  wire [DATA_W-1:0] first_byte = (stage == STG_ADDR_R) ? addr_rd : addr_wr;

  // data bits msb first, ack bit from the receiver
  wire data_drv = ~rx_byte & ~shift[DATA_W-1];
  wire ack_drv  = rx_byte & ~last_rd;
  wire bit_drv  = ack_bit ? ack_drv : data_drv;

  // line drive per state and quarter
  logic next_sda_oe;
  logic next_scl_oe;

  always_comb begin
    next_sda_oe = sda_oe;
    next_scl_oe = scl_oe;
    unique case (state)
      ST_IDLE: begin
        next_sda_oe = 1'b0;
        next_scl_oe = 1'b0;
      end
      ST_START: begin
        unique case (phase)
          PH_0: begin
            next_sda_oe = 1'b0;
            next_scl_oe = active;
          end
          PH_1: begin
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
          end
          PH_2: begin
            next_sda_oe = 1'b1;
            next_scl_oe = 1'b0;
          end
          PH_3: begin
            next_sda_oe = 1'b1;
            next_scl_oe = 1'b1;
          end
        endcase
      end
      ST_BITS: begin
        unique case (phase)
          PH_0: next_scl_oe = 1'b1;
          PH_1: begin
            next_scl_oe = 1'b1;
            next_sda_oe = bit_drv;
          end
          PH_2: next_scl_oe = 1'b0;
          PH_3: next_scl_oe = 1'b0;
        endcase
      end
      ST_WAITD: next_scl_oe = 1'b1;
      ST_STOP: begin
        unique case (phase)
          PH_0: next_scl_oe = 1'b1;
          PH_1: begin
            next_sda_oe = 1'b1;
            next_scl_oe = 1'b1;
          end
          PH_2: begin
            next_sda_oe = 1'b1;
            next_scl_oe = 1'b0;
          end
          PH_3: begin
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
          end
        endcase
      end
      default: begin
        next_sda_oe = 1'b0;
        next_scl_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      sda_oe <= next_sda_oe;
      scl_oe <= next_scl_oe;
    end
  end

  // sample sda at the end of the first high quarter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample <= 1'b1;
    end else if (state == ST_BITS && tick && phase == PH_2) begin
      sample <= lnk.sda_s;
    end
  end

  // command and byte sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= ST_IDLE;
      stage     <= STG_ADDR_W;
      phase     <= PH_0;
      bitn      <= '0;
      shift     <= '0;
      len       <= '0;
      addr      <= '0;
      ptr       <= '0;
      rd_cmd    <= 1'b0;
      active    <= 1'b0;
      cmd_ready <= 1'b1;
      wr_ready  <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      done      <= 1'b0;
      nack      <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (take_cmd) begin
            cmd_ready <= 1'b0;
            nack      <= 1'b0;
            addr      <= cmd_addr;
            ptr       <= cmd_ptr;
            rd_cmd    <= cmd_read;
            len       <= (cmd_read && cmd_len == LEN_ZERO) ? LEN_ONE : cmd_len;
            // read may skip the pointer and continue where it stood
            stage     <= (cmd_read && !cmd_use_ptr) ? STG_ADDR_R : STG_ADDR_W;
            phase     <= PH_0;
            state     <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (last_ph) begin
              active <= 1'b1;
              shift  <= first_byte;
              bitn   <= '0;
              state  <= ST_BITS;
            end
          end
        end
        ST_BITS: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (last_ph && !ack_bit) begin
              bitn  <= bitn + 4'h1;
              shift <= {shift[DATA_W-2:0], sample};
            end else if (last_ph) begin
              bitn <= '0;
              unique case (stage)
                STG_ADDR_W: begin
                  if (got_ack) begin
                    stage <= STG_PTR;
                    shift <= ptr;
                  end else begin
                    nack  <= 1'b1;
                    state <= ST_STOP;
                  end
                end
                STG_PTR: begin
                  if (!got_ack) begin
                    nack  <= 1'b1;
                    state <= ST_STOP;
                  end else if (rd_cmd) begin
                    stage <= STG_ADDR_R;
                    state <= ST_START;
                  end else if (len == LEN_ZERO) begin
                    state <= ST_STOP;
                  end else begin
                    stage    <= STG_WDATA;
                    wr_ready <= 1'b1;
                    state    <= ST_WAITD;
                  end
                end
                STG_WDATA: begin
                  len <= len - 8'h01;
                  if (!got_ack || last_rd) begin
                    nack  <= ~got_ack;
                    state <= ST_STOP;
                  end else begin
                    wr_ready <= 1'b1;
                    state    <= ST_WAITD;
                  end
                end
                STG_ADDR_R: begin
                  if (got_ack) begin
                    stage <= STG_RDATA;
                  end else begin
                    nack  <= 1'b1;
                    state <= ST_STOP;
                  end
                end
                default: begin
                  rd_valid <= 1'b1;
                  rd_data  <= shift;
                  len      <= len - 8'h01;
                  if (last_rd) begin
                    state <= ST_STOP;
                  end
                  // more bytes follow from the next register
                end
              endcase
            end
          end
        end
        ST_WAITD: begin
          // scl held low until the user supplies the byte
          phase <= PH_0;
          if (take_wr) begin
            wr_ready <= 1'b0;
            shift    <= wr_data;
            state    <= ST_BITS;
          end
        end
        ST_STOP: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (last_ph) begin
              active    <= 1'b0;
              done      <= 1'b1;
              cmd_ready <= 1'b1;
              state     <= ST_IDLE;
            end
          end
        end
        default: begin
          state     <= ST_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule : i2chm_master
`default_nettype wire

// [i2chm_checker.sv]
`default_nettype none
module i2chm_checker
  import i2chm_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic done,
  input wire logic nack,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_out,
  input wire logic scl_oe
);
  localparam int START_WIN = 4 * QTR;
  localparam int STOP_WIN  = QTR + 2;
  logic [15:0] hi_cnt;
  logic [7:0]  pulses;
  logic        moved;
  logic        sda_d;
  logic        scl_d;
  wire         take = cmd_valid && cmd_ready;
  // scl high length, sda motion while high, scl pulses since take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 16'h0000;
      pulses <= 8'h00;
      moved  <= 1'b0;
      sda_d  <= 1'b0;
      scl_d  <= 1'b0;
    end else begin
      hi_cnt <= scl_oe ? 16'h0000 : hi_cnt + 16'h0001;
      moved  <= scl_oe ? 1'b0 : (moved || (sda_oe != sda_d));
      pulses <= take ? 8'h00 : pulses + {7'h00, scl_d && !scl_oe};
      sda_d  <= sda_oe;
      scl_d  <= scl_oe;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  open_drain_a: assert property (sda_out == 1'b0 && scl_out == 1'b0)
    else $error("open-drain output driven high");
  idle_release_a: assert property (cmd_ready |-> !sda_oe && !scl_oe)
    else $error("line pulled while idle");
  start_soon_a: assert property (take |-> ##[1:START_WIN] ($rose(sda_oe) && !scl_oe))
    else $error("no start after command");
  start_quarter_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[QTR:QTR] $rose(scl_oe))
    else $error("start not followed by scl low one quarter later");
  stop_done_a: assert property ($fell(sda_oe) && !scl_oe && $past(!scl_oe) |-> ##[0:STOP_WIN] done)
    else $error("stop without done");
  // two quarters plus the two synchroniser cycles spent waiting for scl to be seen high
  hi_period_a: assert property ($rose(scl_oe) && !moved |-> hi_cnt == 16'(2 * QTR + 2))
    else $error("scl high period wrong");
  stall_hold_a: assert property (wr_ready && !wr_valid |=> scl_oe)
    else $error("scl released while waiting for data");
  unit_nine_a: assert property ($rose(wr_ready) |-> pulses % 8'h09 == 8'h00 && pulses >= 8'h12)
    else $error("data request not on a nine pulse boundary");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  nack_hold_a: assert property (nack && !take |=> nack)
    else $error("nack flag lost");
endmodule : i2chm_checker
`default_nettype wire

// [i2chm_dev_model.sv]
`default_nettype none
module i2chm_dev_model (
  input  wire logic sda,
  input  wire logic scl,
  input  wire logic strap,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] ptr = 8'h00;
  logic [7:0] sh;
  logic [3:0] cnt = 4'h0;
  logic       act = 1'b0, tx = 1'b0, rw, first, got, mack;
  wire  [6:0] own = strap ? 7'h48 : 7'h40;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    sda_pull = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    first = 1'b1;
    got = 1'b0;
    tx = 1'b0;
    cnt = 4'h0;
    sda_pull = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sda_pull = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (cnt < 4'h8 && !tx) sh = {sh[6:0], sda};
    if (cnt == 4'h8) mack = sda;
    cnt = cnt + 4'h1;
  end
  always @(negedge scl) if (act) begin
    if (cnt == 4'h8 && tx) sda_pull = 1'b0;
    else if (cnt == 4'h8 && first) begin
      first = 1'b0;
      rw = sh[0];
      act = (sh[7:1] == own);
      sda_pull = act;
    end else if (cnt == 4'h8 && !got) begin
      ptr = sh;
      got = 1'b1;
      sda_pull = 1'b1;
    end else if (cnt == 4'h8) begin
      mem[ptr] = sh;
      ptr = ptr + 8'h01;
      sda_pull = 1'b1;
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      act = !(tx && mack);
      tx = rw;
      if (act && tx) begin
        sh = mem[ptr];
        ptr = ptr + 8'h01;
      end
      sda_pull = act && tx && !sh[7];
    end else if (tx) sda_pull = !sh[3'(7 - cnt)];
  end
endmodule : i2chm_dev_model
`default_nettype wire

// [test_i2chm_master.sv]
`default_nettype none
module test_i2chm_master;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 4;
  // fl: read, use pointer, strap, stall
  typedef struct packed {
    logic [3:0] fl;
    logic [6:0] addr;
    logic [7:0] ptr, len, d0, d1;
    logic       nk;
  } i2chm_row_type;
  i2chm_row_type rows [12] = '{
    '{4'h2, 7'h48, 8'h10, 8'h02, 8'hA1, 8'hB2, 1'b0},
    '{4'hE, 7'h48, 8'h10, 8'h02, 8'h00, 8'h00, 1'b0},
    '{4'hA, 7'h48, 8'h00, 8'h01, 8'h00, 8'h00, 1'b0},
    '{4'h2, 7'h00, 8'h20, 8'h01, 8'h11, 8'h00, 1'b1},
    '{4'h2, 7'h23, 8'h20, 8'h01, 8'h11, 8'h00, 1'b1},
    '{4'h0, 7'h48, 8'h20, 8'h01, 8'h11, 8'h00, 1'b1},
    '{4'h0, 7'h40, 8'hFF, 8'h02, 8'hC3, 8'h3C, 1'b0},
    '{4'hC, 7'h40, 8'hFF, 8'h02, 8'h00, 8'h00, 1'b0},
    '{4'h3, 7'h48, 8'h30, 8'h01, 8'h5C, 8'h00, 1'b0},
    '{4'h2, 7'h48, 8'h30, 8'h00, 8'h00, 8'h00, 1'b0},
    '{4'hA, 7'h48, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0},
    '{4'hA, 7'h23, 8'h00, 8'h01, 8'h00, 8'h00, 1'b1}
  };
  logic       clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_use_ptr = 1'b0;
  logic       wr_valid = 1'b0, strap = 1'b1, dev_pull;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_ptr = 8'h00, cmd_len = 8'h00, wr_data = 8'h00, rd_data, exp_ptr = 8'h00;
  logic       cmd_ready, wr_ready, rd_valid, done, nack, sda_out, sda_oe, scl_out, scl_oe;
  logic [7:0] exp_mem [256];
  int         failures = 0, samples_checked = 0, cycles = 0;
  wire        sda_w = !(sda_oe || dev_pull);
  wire        scl_w = !scl_oe;
  i2chm_master #(.QTR(Q)) u_dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_use_ptr(cmd_use_ptr), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .nack(nack), .sda_in(sda_w), .scl_in(scl_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
  i2chm_dev_model u_dev (.sda(sda_w), .scl(scl_w), .strap(strap), .sda_pull(dev_pull));
  always #4 clk = ~clk;
  task automatic report_and_stop;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic chk_reset;
    chk1(cmd_ready, 1'b1);
    chk1(sda_oe | scl_oe, 1'b0);
    chk1(wr_ready | rd_valid | done | nack, 1'b0);
    chk8(rd_data, 8'h00);
  endtask : chk_reset
  task automatic run_row(input i2chm_row_type r);
    int         n;
    logic       fin;
    logic       take;
    logic [7:0] k;
    n = 0;
    fin = 1'b0;
    k = 8'h00;
    if (r.fl[3] && r.fl[2]) exp_ptr = r.ptr;
    @(posedge clk);
    strap       <= r.fl[1];
    cmd_valid   <= 1'b1;
    cmd_read    <= r.fl[3];
    cmd_use_ptr <= r.fl[2];
    cmd_addr    <= r.addr;
    cmd_ptr     <= r.ptr;
    cmd_len     <= r.len;
    wr_data     <= r.d0;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (!fin && n < 4000) begin
      @(negedge clk);
      n++;
      if (rd_valid === 1'b1) begin
        chk8(rd_data, exp_mem[exp_ptr]);
        exp_ptr++;
        k++;
      end
      fin  = (done === 1'b1);
      take = (wr_ready === 1'b1 && wr_valid === 1'b1);
      @(posedge clk);
      if (take) wr_data <= r.d1;
      wr_valid <= !fin && !r.fl[3] && (n > (r.fl[0] ? 700 : 0));
    end
    if (!fin) failures++;
    chk1(nack, r.nk);
    chk1(sda_w & scl_w, 1'b1);
    chk8(k, (r.fl[3] && !r.nk) ? (r.len == 8'h00 ? 8'h01 : r.len) : 8'h00);
    if (!r.nk && !r.fl[3]) begin
      for (int j = 0; j < r.len; j++) exp_mem[8'(r.ptr + j)] = (j == 0) ? r.d0 : r.d1;
      exp_ptr = r.ptr + r.len;
    end
  endtask : run_row
  initial begin
    for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i) ^ 8'h5A;
    repeat (10) @(posedge clk);
    chk_reset();
    rstn <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    // reset while a write waits for its data byte
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read  <= 1'b0;
    cmd_addr  <= 7'h48;
    cmd_ptr   <= 8'h10;
    cmd_len   <= 8'h01;
    repeat (400) @(posedge clk);
    cmd_valid <= 1'b0;
    rstn      <= 1'b0;
    @(negedge clk);
    chk_reset();
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    run_row('{4'hE, 7'h48, 8'h10, 8'h01, 8'h00, 8'h00, 1'b0});
    report_and_stop();
  end
endmodule : test_i2chm_master
bind i2chm_master i2chm_checker #(.QTR(QTR)) u_chk (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_ready(wr_ready), .done(done), .nack(nack),
  .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));
`default_nettype wire
